// *** verilog/power_event_pkg.sv ***
// Constants, field layout and state type of the power button event logic
package power_event_pkg;

  // ==========================================================
  // Timing
  localparam real CLK_PERIOD_NS   = 4.0;
  localparam real DBNC_SHORT_MS   = 31.25;
  localparam real DBNC_MID_MS     = 125.0;
  localparam real DBNC_LONG_MS    = 750.0;
  localparam real LONG_PRESS_S    = 4.0;
  localparam int  DBNC_SHORT_CYC  = int'($ceil(DBNC_SHORT_MS * 1.0e6 / CLK_PERIOD_NS));
  localparam int  DBNC_MID_CYC    = int'($ceil(DBNC_MID_MS * 1.0e6 / CLK_PERIOD_NS));
  localparam int  DBNC_LONG_CYC   = int'($ceil(DBNC_LONG_MS * 1.0e6 / CLK_PERIOD_NS));
  localparam int  LONG_PRESS_CYC  = int'($ceil(LONG_PRESS_S * 1.0e9 / CLK_PERIOD_NS));
  localparam int  CNT_W           = 32;
  localparam int  MAX_REGS        = 8;

  // ==========================================================
  // Register offsets (byte addresses)
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_REGS   = 8'h08;

  // ==========================================================
  // Control fields and reset values
  localparam int CTRL_MODE_BIT    = 0;
  localparam int CTRL_DBNC_LSB    = 1;
  localparam int CTRL_LPOFF_BIT   = 3;
  localparam int CTRL_RESTART_BIT = 4;
  localparam int CTRL_RETAIN_LSB  = 8;
  localparam logic       MODE_RST    = 1'b0;
  localparam logic [1:0] DBNC_RST    = 2'h0;
  localparam logic       LPOFF_RST   = 1'b1;
  localparam logic       RESTART_RST = 1'b0;

  // ==========================================================
  // Status and regulator fields
  localparam int STAT_FLAG_BIT  = 0;
  localparam int STAT_SENSE_BIT = 1;
  localparam int STAT_STATE_LSB = 2;
  localparam int STAT_VIN_BIT   = 4;
  localparam int STAT_THERM_BIT = 5;
  localparam int REGS_ON_LSB    = 0;
  localparam int REGS_SLEEP_LSB = 8;

  typedef enum logic [1:0] {ST_OFF, ST_COIN, ST_SLEEP, ST_ON} power_state_t;

endpackage

// *** verilog/level_qualifier.sv ***
// Pulses once when a level has held its wanted value for a set count
`timescale 1ns/100ps
`default_nettype none
module level_qualifier
#(
  parameter int CW = 32
)
(
  // Clock and reset
  input  wire logic          clock,
  input  wire logic          sys_rst,
  // Level and qualification
  input  wire logic          level,
  input  wire logic          wanted,
  input  wire logic [CW-1:0] threshold,
  output logic               fire_ff
);

  logic [CW-1:0] cnt_ff;
  logic          done_ff;

  // ==========================================================
  // Hold counter
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      // Armed only after the level has left its wanted value once
      cnt_ff  <= '0;
      done_ff <= 1'b1;
      fire_ff <= 1'b0;
    end
    else
    begin
      fire_ff <= 1'b0;
      if (level != wanted)
      begin
        cnt_ff  <= '0;
        done_ff <= 1'b0;
      end
      else if (!done_ff)
      begin
        if (cnt_ff >= threshold)
        begin
          fire_ff <= 1'b1;
          done_ff <= 1'b1;
        end
        else
          cnt_ff <= cnt_ff + 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

// *** verilog/power_button_event_control.sv ***
// Turn-on and turn-off event control with a Wishbone register slave
`timescale 1ns/100ps
`default_nettype none
module power_button_event_control
#(
  parameter int NUM_REGS       = 8,
  parameter int DBNC_SHORT_CYC = power_event_pkg::DBNC_SHORT_CYC,
  parameter int DBNC_MID_CYC   = power_event_pkg::DBNC_MID_CYC,
  parameter int DBNC_LONG_CYC  = power_event_pkg::DBNC_LONG_CYC,
  parameter int LONG_PRESS_CYC = power_event_pkg::LONG_PRESS_CYC
)
(
  // Clock and reset
  input  wire logic                    clock,
  input  wire logic                    sys_rst,
  // Wishbone slave
  input  wire logic                    cyc_i,
  input  wire logic                    stb_i,
  input  wire logic                    we_i,
  input  wire logic [7:0]              adr_i,
  input  wire logic [3:0]              sel_i,
  input  wire logic [31:0]             dat_i,
  output logic [31:0]                  dat_o,
  output logic                         ack_o,
  // Pin and supply indications
  input  wire logic                    power_request_pin,
  input  wire logic                    vin_above_uv_threshold,
  input  wire logic                    thermal_shutdown,
  // Power state, regulator commands, pin event flag and pin level sense
  output var power_event_pkg::power_state_t power_state_ff,
  output logic [NUM_REGS-1:0]          regulator_on_ff,
  output logic [NUM_REGS-1:0]          regulator_sleep_ff,
  output logic                         sequence_start_ff,
  output logic [NUM_REGS-1:0]          sequence_mask_ff,
  output logic                         pin_event_flag_ff,
  output logic                         pin_level_sense_ff
);

  localparam int CW = power_event_pkg::CNT_W;

  logic                  pin_meta_ff;
  logic                  pin_sync_ff;
  logic                  pin_mode_select_ff;
  logic [1:0]            button_debounce_select_ff;
  logic                  long_press_off_enable_ff;
  logic                  auto_restart_enable_ff;
  logic [NUM_REGS-1:0]   sleep_retain_select_ff;
  logic                  restart_ff;
  logic                  nxt_restart;
  power_event_pkg::power_state_t nxt_state;
  logic [CW-1:0]         fall_thr;
  logic [CW-1:0]         on_thr;
  logic                  fall_fire;
  logic                  rise_fire;
  logic                  on_fire;
  logic                  long_fire;
  logic                  turn_on_req;
  logic                  pin_off;
  logic                  on_entry;
  logic                  off_entry;
  logic                  flag_set;
  logic                  flag_clr;
  logic                  wr_take;
  logic [31:0]           rd_word;

  // ==========================================================
  // Pin synchroniser and sense
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      // Idle level of the pulled-up pin in both synchroniser stages, no false edge after reset; sense bit starts low
      pin_meta_ff        <= 1'b1;
      pin_sync_ff        <= 1'b1;
      pin_level_sense_ff <= 1'b0;
    end
    else
    begin
      pin_meta_ff        <= power_request_pin;
      pin_sync_ff        <= pin_meta_ff;
      pin_level_sense_ff <= pin_sync_ff;
    end
  end

  // ==========================================================
  // Debounce selection
  always_comb
  begin
    fall_thr = CW'(DBNC_SHORT_CYC);
    on_thr   = '0;
    case (button_debounce_select_ff)
      2'h0:
      begin
        fall_thr = CW'(DBNC_SHORT_CYC);
        on_thr   = '0;
      end
      2'h1:
      begin
        fall_thr = CW'(DBNC_SHORT_CYC);
        on_thr   = CW'(DBNC_SHORT_CYC);
      end
      2'h2:
      begin
        fall_thr = CW'(DBNC_MID_CYC);
        on_thr   = CW'(DBNC_MID_CYC);
      end
      default:
      begin
        fall_thr = CW'(DBNC_LONG_CYC);
        on_thr   = CW'(DBNC_LONG_CYC);
      end
    endcase
  end

  level_qualifier #(.CW(CW)) u_fall_int
  (
    .clock     (clock),
    .sys_rst   (sys_rst),
    .level     (pin_sync_ff),
    .wanted    (1'b0),
    .threshold (fall_thr),
    .fire_ff   (fall_fire)
  );

  level_qualifier #(.CW(CW)) u_rise_int
  (
    .clock     (clock),
    .sys_rst   (sys_rst),
    .level     (pin_sync_ff),
    .wanted    (1'b1),
    .threshold (CW'(DBNC_SHORT_CYC)),
    .fire_ff   (rise_fire)
  );

  level_qualifier #(.CW(CW)) u_turn_on
  (
    .clock     (clock),
    .sys_rst   (sys_rst),
    .level     (pin_sync_ff),
    .wanted    (1'b0),
    .threshold (on_thr),
    .fire_ff   (on_fire)
  );

  level_qualifier #(.CW(CW)) u_long_press
  (
    .clock     (clock),
    .sys_rst   (sys_rst),
    .level     (pin_sync_ff),
    .wanted    (1'b0),
    .threshold (CW'(LONG_PRESS_CYC)),
    .fire_ff   (long_fire)
  );

  // ==========================================================
  // Wishbone slave
  assign wr_take = cyc_i && stb_i && we_i && ack_o;

  always_comb
  begin
    rd_word = '0;
    if (adr_i == power_event_pkg::ADDR_CTRL)
    begin
      rd_word[power_event_pkg::CTRL_MODE_BIT]         = pin_mode_select_ff;
      rd_word[power_event_pkg::CTRL_DBNC_LSB +: 2]    = button_debounce_select_ff;
      rd_word[power_event_pkg::CTRL_LPOFF_BIT]        = long_press_off_enable_ff;
      rd_word[power_event_pkg::CTRL_RESTART_BIT]      = auto_restart_enable_ff;
      rd_word[power_event_pkg::CTRL_RETAIN_LSB +: NUM_REGS] = sleep_retain_select_ff;
    end
    else if (adr_i == power_event_pkg::ADDR_STATUS)
    begin
      rd_word[power_event_pkg::STAT_FLAG_BIT]      = pin_event_flag_ff;
      rd_word[power_event_pkg::STAT_SENSE_BIT]     = pin_level_sense_ff;
      rd_word[power_event_pkg::STAT_STATE_LSB +: 2] = power_state_ff;
      rd_word[power_event_pkg::STAT_VIN_BIT]       = vin_above_uv_threshold;
      rd_word[power_event_pkg::STAT_THERM_BIT]     = thermal_shutdown;
    end
    else if (adr_i == power_event_pkg::ADDR_REGS)
    begin
      rd_word[power_event_pkg::REGS_ON_LSB +: NUM_REGS]    = regulator_on_ff;
      rd_word[power_event_pkg::REGS_SLEEP_LSB +: NUM_REGS] = regulator_sleep_ff;
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      ack_o <= 1'b0;
      dat_o <= '0;
    end
    else
    begin
      ack_o <= cyc_i && stb_i && !ack_o;
      if (cyc_i && stb_i && !ack_o && !we_i)
        dat_o <= rd_word;
    end
  end

  // ==========================================================
  // Control register
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      pin_mode_select_ff        <= power_event_pkg::MODE_RST;
      button_debounce_select_ff <= power_event_pkg::DBNC_RST;
      long_press_off_enable_ff  <= power_event_pkg::LPOFF_RST;
      auto_restart_enable_ff    <= power_event_pkg::RESTART_RST;
      sleep_retain_select_ff    <= '0;
    end
    else if (wr_take && adr_i == power_event_pkg::ADDR_CTRL)
    begin
      if (sel_i[0])
      begin
        pin_mode_select_ff        <= dat_i[power_event_pkg::CTRL_MODE_BIT];
        button_debounce_select_ff <= dat_i[power_event_pkg::CTRL_DBNC_LSB +: 2];
        long_press_off_enable_ff  <= dat_i[power_event_pkg::CTRL_LPOFF_BIT];
        auto_restart_enable_ff    <= dat_i[power_event_pkg::CTRL_RESTART_BIT];
      end
      if (sel_i[1])
        sleep_retain_select_ff <= dat_i[power_event_pkg::CTRL_RETAIN_LSB +: NUM_REGS];
    end
  end

  // ==========================================================
  // Power state machine
  assign turn_on_req = pin_mode_select_ff ? on_fire : pin_sync_ff;
  assign pin_off = pin_mode_select_ff
                 ? (long_press_off_enable_ff && long_fire)
                 : !pin_sync_ff;

  always_comb
  begin
    nxt_state   = power_state_ff;
    nxt_restart = restart_ff;
    if (!vin_above_uv_threshold)
    begin
      nxt_state   = power_event_pkg::ST_COIN;
      nxt_restart = 1'b0;
    end
    else if (thermal_shutdown)
    begin
      nxt_state   = power_event_pkg::ST_OFF;
      nxt_restart = 1'b0;
    end
    else
    begin
      case (power_state_ff)
        power_event_pkg::ST_COIN:
          nxt_state = power_event_pkg::ST_OFF;
        power_event_pkg::ST_OFF,
        power_event_pkg::ST_SLEEP:
        begin
          if (turn_on_req || restart_ff)
          begin
            nxt_state   = power_event_pkg::ST_ON;
            nxt_restart = 1'b0;
          end
        end
        power_event_pkg::ST_ON:
        begin
          if (pin_off)
          begin
            if (|sleep_retain_select_ff)
              nxt_state = power_event_pkg::ST_SLEEP;
            else
            begin
              nxt_state   = power_event_pkg::ST_OFF;
              nxt_restart = auto_restart_enable_ff;
            end
          end
        end
        default:
          nxt_state = power_event_pkg::ST_OFF;
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      power_state_ff <= power_event_pkg::ST_OFF;
      restart_ff     <= 1'b0;
    end
    else
    begin
      power_state_ff <= nxt_state;
      restart_ff     <= nxt_restart;
    end
  end

  // ==========================================================
  // Pin event flag, set wins over clear
  assign on_entry  = (nxt_state == power_event_pkg::ST_ON)
                  && (power_state_ff != power_event_pkg::ST_ON);
  assign off_entry = (nxt_state == power_event_pkg::ST_OFF)
                  && (power_state_ff != power_event_pkg::ST_OFF);
  assign flag_set  = on_entry
                  || (pin_mode_select_ff && (fall_fire || rise_fire));
  assign flag_clr  = off_entry
                  || (wr_take && adr_i == power_event_pkg::ADDR_STATUS
                      && sel_i[0] && dat_i[power_event_pkg::STAT_FLAG_BIT]);

  always_ff @(posedge clock)
  begin
    if (sys_rst)
      pin_event_flag_ff <= 1'b0;
    else if (flag_set)
      pin_event_flag_ff <= 1'b1;
    else if (flag_clr)
      pin_event_flag_ff <= 1'b0;
  end

  // ==========================================================
  // Regulator commands
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      regulator_on_ff    <= '0;
      regulator_sleep_ff <= '0;
      sequence_start_ff  <= 1'b0;
      sequence_mask_ff   <= '0;
    end
    else
    begin
      sequence_start_ff <= 1'b0;
      if (on_entry)
      begin
        regulator_on_ff    <= '1;
        regulator_sleep_ff <= '0;
        sequence_start_ff  <= 1'b1;
        sequence_mask_ff   <= ~regulator_on_ff;
      end
      else if (nxt_state == power_event_pkg::ST_SLEEP
               && power_state_ff != power_event_pkg::ST_SLEEP)
      begin
        regulator_on_ff    <= sleep_retain_select_ff;
        regulator_sleep_ff <= sleep_retain_select_ff;
      end
      else if (nxt_state == power_event_pkg::ST_OFF
               || nxt_state == power_event_pkg::ST_COIN)
      begin
        regulator_on_ff    <= '0;
        regulator_sleep_ff <= '0;
      end
    end
  end

  // ==========================================================
  // Assertions
  logic [1:0] up_cnt_ff;

  always_ff @(posedge clock)
  begin
    if (sys_rst)
      up_cnt_ff <= 2'h0;
    else if (up_cnt_ff != 2'h3)
      up_cnt_ff <= up_cnt_ff + 2'h1;
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  a_sense_live_pin: assert property (
    (up_cnt_ff == 2'h3) |-> pin_level_sense_ff == $past(power_request_pin, 3))
    else $error("sense bit does not follow pin");

  a_uv_to_coin: assert property (
    !vin_above_uv_threshold |=> power_state_ff == power_event_pkg::ST_COIN)
    else $error("undervoltage did not reach coin-cell state");

  a_thermal_forces_off: assert property (
    (vin_above_uv_threshold && thermal_shutdown)
      |=> power_state_ff == power_event_pkg::ST_OFF)
    else $error("thermal shutdown did not force off");

  a_on_needs_supply: assert property (
    (power_state_ff == power_event_pkg::ST_ON
      && $past(power_state_ff) != power_event_pkg::ST_ON)
      |-> $past(vin_above_uv_threshold) && !$past(thermal_shutdown))
    else $error("turned on without valid supply");

  a_level_turn_on: assert property (
    (!pin_mode_select_ff && pin_sync_ff && vin_above_uv_threshold
      && !thermal_shutdown && power_state_ff == power_event_pkg::ST_OFF)
      |=> power_state_ff == power_event_pkg::ST_ON && pin_event_flag_ff)
    else $error("level mode turn-on missed");

  a_level_turn_off: assert property (
    (!pin_mode_select_ff && !pin_sync_ff && vin_above_uv_threshold
      && !thermal_shutdown && sleep_retain_select_ff == '0
      && power_state_ff == power_event_pkg::ST_ON)
      |=> power_state_ff == power_event_pkg::ST_OFF)
    else $error("level mode turn-off missed");

  a_flag_set_wins: assert property (
    flag_set |=> pin_event_flag_ff)
    else $error("flag event lost");

  a_flag_off_clear: assert property (
    (off_entry && !flag_set) |=> !pin_event_flag_ff)
    else $error("entering off did not clear flag");

  a_sleep_keeps_on: assert property (
    (power_state_ff == power_event_pkg::ST_SLEEP
      && nxt_state == power_event_pkg::ST_ON)
      |=> ((regulator_on_ff & $past(regulator_on_ff)) == $past(regulator_on_ff))
          && sequence_start_ff)
    else $error("retained regulator dropped on wake");

  a_ack_single: assert property (
    ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");

  c_level_on: cover property (
    power_state_ff == power_event_pkg::ST_OFF
    ##1 power_state_ff == power_event_pkg::ST_ON);
  c_enter_sleep: cover property (
    power_state_ff == power_event_pkg::ST_ON
    ##1 power_state_ff == power_event_pkg::ST_SLEEP);
  c_auto_restart: cover property (
    restart_ff ##1 power_state_ff == power_event_pkg::ST_ON);
  c_coin_cell: cover property (
    power_state_ff == power_event_pkg::ST_COIN);

endmodule
`default_nettype wire

// *** tb/push_button_model.sv ***
// Push button on the power request pin, pulled up to the backup rail
`timescale 1ns/100ps
`default_nettype none
module push_button_model
(
  // Clock
  input  wire logic clock,
  // Bench command
  input  wire logic pressed,
  // Pin
  output logic      pin_ff
);
  // ==========================================================
  // Released contact lets the pull-up take the pin high
  initial
  begin
    pin_ff = 1'b1;
    forever
    begin
      @(posedge clock);
      pin_ff <= ~pressed;
    end
  end
endmodule
`default_nettype wire

// *** tb/power_button_event_control_bench.sv ***
// Self-checking bench for the power button event control
`timescale 1ns/100ps
`default_nettype none
module power_button_event_control_bench;
  logic        clock = 1'b0;
  logic        sys_rst = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic        ack;
  logic        pressed = 1'b0;
  logic        pin;
  logic        vin_ok = 1'b0;
  logic        therm = 1'b0;
  power_event_pkg::power_state_t state;
  logic [7:0]  reg_on;
  logic [7:0]  reg_sleep;
  logic [7:0]  seq_mask;
  logic        seq_start;
  logic        flag;
  logic        sense;
  logic [31:0] q;
  int          bad_count = 0;
  int          comparisons = 0;

  initial forever #2 clock = ~clock;

  power_button_event_control
  #(
    .NUM_REGS      (8),
    .DBNC_SHORT_CYC(20),
    .DBNC_MID_CYC  (40),
    .DBNC_LONG_CYC (80),
    .LONG_PRESS_CYC(200)
  )
  i_dut
  (
    .clock                 (clock),
    .sys_rst               (sys_rst),
    .cyc_i                 (cyc),
    .stb_i                 (stb),
    .we_i                  (we),
    .adr_i                 (adr),
    .sel_i                 (sel),
    .dat_i                 (wdat),
    .dat_o                 (rdat),
    .ack_o                 (ack),
    .power_request_pin     (pin),
    .vin_above_uv_threshold(vin_ok),
    .thermal_shutdown      (therm),
    .power_state_ff        (state),
    .regulator_on_ff       (reg_on),
    .regulator_sleep_ff    (reg_sleep),
    .sequence_start_ff     (seq_start),
    .sequence_mask_ff      (seq_mask),
    .pin_event_flag_ff     (flag),
    .pin_level_sense_ff    (sense)
  );

  push_button_model i_button
  (
    .clock  (clock),
    .pressed(pressed),
    .pin_ff (pin)
  );

  // ==========================================================
  // Report and checks
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wait_state(input power_event_pkg::power_state_t s,
                            input int bound);
    int n;
    n = 0;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (state !== s && n < bound);
    chk("state", 32'(s), 32'(state));
    if (state !== s)
      wrap_up();
  endtask

  // ==========================================================
  // Wishbone classic single cycle
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hF;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (ack !== 1'b1 && n < 50);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 50)
    begin
      bad_count++;
      wrap_up();
    end
  endtask

  task automatic hold(input int n);
    repeat (n) @(posedge clock);
  endtask

  // ==========================================================
  // Scenarios
  initial
  begin
    hold(6);
    sys_rst <= 1'b0;
    wait_state(power_event_pkg::ST_COIN, 10);
    wb(1'b0, power_event_pkg::ADDR_CTRL, 32'h0);
    chk("ctrl reset", 32'h00000008, q);
    wb(1'b0, 8'h0C, 32'h0);
    chk("unmapped", 32'h00000000, q);
    wb(1'b0, power_event_pkg::ADDR_STATUS, 32'h0);
    chk("on refused", 32'h6, 32'(q[3:0]));
    vin_ok <= 1'b1;
    wait_state(power_event_pkg::ST_ON, 20);
    wb(1'b0, power_event_pkg::ADDR_STATUS, 32'h0);
    chk("flag sense", 32'h3, 32'(q[1:0]));
    chk("regs on", 32'hFF, 32'(reg_on));
    pressed <= 1'b1;
    wait_state(power_event_pkg::ST_OFF, 20);
    chk("flag off", 32'h0, 32'(flag));
    therm <= 1'b1;
    pressed <= 1'b0;
    hold(20);
    chk("therm state", 32'(power_event_pkg::ST_OFF), 32'(state));
    chk("therm flag", 32'h0, 32'(flag));
    therm <= 1'b0;
    wait_state(power_event_pkg::ST_ON, 20);
    wb(1'b1, power_event_pkg::ADDR_STATUS, 32'h1);
    hold(1);
    chk("flag clear", 32'h0, 32'(flag));
    wb(1'b1, power_event_pkg::ADDR_CTRL, 32'h109);
    pressed <= 1'b1;
    hold(100);
    chk("short press", 32'(power_event_pkg::ST_ON), 32'(state));
    wb(1'b0, power_event_pkg::ADDR_STATUS, 32'h0);
    chk("sense low", 32'h1, 32'(q[1:0]));
    wait_state(power_event_pkg::ST_SLEEP, 300);
    chk("sleep regs", 32'h01, 32'(reg_sleep));
    pressed <= 1'b0;
    hold(40);
    wb(1'b1, power_event_pkg::ADDR_STATUS, 32'h1);
    pressed <= 1'b1;
    wait_state(power_event_pkg::ST_ON, 10);
    chk("seq mask", 32'hFE, 32'(seq_mask));
    chk("seq start", 32'h1, 32'(seq_start));
    chk("flag on", 32'h1, 32'(flag));
    hold(30);
    wb(1'b1, power_event_pkg::ADDR_STATUS, 32'h1);
    pressed <= 1'b0;
    hold(10);
    chk("rise early", 32'h0, 32'(flag));
    hold(30);
    chk("rise flag", 32'h1, 32'(flag));
    wb(1'b1, power_event_pkg::ADDR_CTRL, 32'h0D);
    wb(1'b1, power_event_pkg::ADDR_STATUS, 32'h1);
    pressed <= 1'b1;
    hold(30);
    chk("fall slow", 32'h0, 32'(flag));
    hold(20);
    chk("fall flag", 32'h1, 32'(flag));
    wait_state(power_event_pkg::ST_OFF, 300);
    pressed <= 1'b0;
    hold(60);
    pressed <= 1'b1;
    hold(30);
    chk("slow on", 32'(power_event_pkg::ST_OFF), 32'(state));
    wait_state(power_event_pkg::ST_ON, 30);
    wb(1'b1, power_event_pkg::ADDR_CTRL, 32'h1D);
    wait_state(power_event_pkg::ST_OFF, 300);
    wait_state(power_event_pkg::ST_ON, 5);
    pressed <= 1'b0;
    hold(5);
    vin_ok <= 1'b0;
    wait_state(power_event_pkg::ST_COIN, 5);
    wrap_up();
  end

  initial
  begin
    hold(20000);
    bad_count++;
    wrap_up();
  end
endmodule
`default_nettype wire
